//--- src/iso_tx_hdr_defs.vh
`ifndef ISO_TX_HDR_DEFS_VH
`define ISO_TX_HDR_DEFS_VH

// register byte addresses
`define A_PORT_CFG      8'h00
`define A_BUF_CFG0      8'h04
`define A_ISO_HDR       8'h08
`define A_CIP_FIRST     8'h0C
`define A_CIP_SECOND    8'h10
`define A_EXTRA_HDR     8'h14
`define A_ACCESS        8'h18
`define A_LAST_ACCESS   8'h1C
`define A_STATUS        8'h20

// tx_port_config fields
`define CFG_HIM         0
`define CFG_OVR         1
`define CFG_CLS_LO      4
`define CFG_CLS_HI      6
// buffer_config0 fields
`define BC_TSI          0
`define BC_KIND_LO      1
`define BC_KIND_HI      3
`define KIND_MPEG2      3'h0

// reset values of buffer 0
`define RST_ISO_HDR     32'h00084010
`define RST_CIP_FIRST   32'h0006C400
`define RST_CIP_SECOND  32'hA0000000
`define RST_ZERO        32'h00000000
`define RST_DBC         8'h00

// header field values and positions
`define TAG_CIP         2'h1
`define TCODE_ISO       4'hA
`define SPD_S100        2'h0
`define SPD_S200        2'h1
`define SPD_S400        2'h2
`define SPD_LO          6
`define SPD_HI          7
`define CHAN_LO         8
`define CHAN_HI         13
`define SY_HI           3

// packet sizing
`define SP_QUADS        6'd48
`define FRAG_QUADS      16'd6
`define CIP_BYTES       16'd8
`define FRAC_CLASSES    3'd3
`define SP_CLASS_BASE   3'd2
`define FN_WHOLE        2'h0
`define SP_MAX          5

// status fields
`define ST_BUSY         8

// bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

//--- src/iso_mpeg2_tx_header_inserter.v
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "iso_tx_hdr_defs.vh"

// Notes on behaviour
// - auto mode: device builds all headers, source raw
// - insert mode on: headers precede payload
// - tag field always 01
// - transaction code A on every packet
// - speed 00/01/10 for S100/S200/S400
// - data length equals payload bytes
// - payload order: CIP0, CIP1, stamp, stream
// - buffer 0 resets to default header values
// - quadlet aligned data, no padding added
// - CIP fields updated by hardware per packet
// - packet size from class 0 to 7
// - class sets allowed packet sizes
// - source packet is 192 bytes
module iso_mpeg2_tx_header_inserter #(
  parameter DEPTH = 256,
  parameter AW    = 8
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        in_valid,
  input  wire [31:0] in_data,
  input  wire        in_last,
  output reg         in_ready_ff,
  input  wire        cycle_start,
  input  wire [31:0] ts_value,
  output reg         out_valid_ff,
  output reg  [31:0] out_data_ff,
  output reg         out_first_ff,
  output reg         out_last_ff,
  output reg  [3:0]  out_tcode_ff,
  input  wire        out_ready
);

  localparam S_IDLE = 3'h0;
  localparam S_ISO  = 3'h1;
  localparam S_CIP0 = 3'h2;
  localparam S_CIP1 = 3'h3;
  localparam S_DATA = 3'h4;
  localparam S_RAW  = 3'h5;

  // registers
  reg [31:0] port_cfg_ff;
  reg [31:0] buf_cfg_ff;
  reg [31:0] iso_hdr_ff;
  reg [31:0] cip_first_ff;
  reg [31:0] cip_second_ff;
  reg [31:0] extra_hdr_ff;
  reg [7:0]  dbc_ff;
  // bus slave state
  reg [7:0]  aw_addr_ff;
  reg        aw_held_ff;
  reg [31:0] w_data_ff;
  reg [3:0]  w_strb_ff;
  reg        w_held_ff;
  // data buffer
  reg [32:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wptr_ff;
  reg [AW-1:0] rptr_ff;
  reg [AW:0]   count_ff;
  reg [AW:0]   last_cnt_ff;
  // packet state
  reg [2:0]  state_ff;
  reg [15:0] left_ff;
  reg [15:0] len_ff;
  reg [7:0]  blocks_ff;
  reg [5:0]  sp_q_ff;
  wire        header_insert_mode     = port_cfg_ff[`CFG_HIM];
  wire        ovr     = port_cfg_ff[`CFG_OVR];
  wire [2:0]  cls     = port_cfg_ff[`CFG_CLS_HI:`CFG_CLS_LO];
  wire        tsi     = buf_cfg_ff[`BC_TSI];
  wire        mpeg    = buf_cfg_ff[`BC_KIND_HI:`BC_KIND_LO] == `KIND_MPEG2;
  wire        frac    = cls <= `FRAC_CLASSES;
  wire [32:0] head    = mem[rptr_ff];
  wire        slot    = !out_valid_ff || out_ready;
  wire        stamp   = tsi && sp_q_ff == 6'd0;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        merge[i*8 +: 8] = strb[i] ? val[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // whole source packets that fit in the buffer, capped by the class
  function [7:0] sp_fit;
    input [AW:0] avail;
    input [2:0]  c;
    input        ts;
    reg   [15:0] need;
    integer k;
    begin
      sp_fit = 8'd0;
      need = ts ? {10'd0, `SP_QUADS} - 16'd1 : {10'd0, `SP_QUADS};
      for (k = 1; k <= `SP_MAX; k = k + 1) begin
        sp_fit = (k <= c - `SP_CLASS_BASE && {{(15-AW){1'b0}}, avail} >= need * k[15:0]) ? k[7:0] : sp_fit;
      end
    end
  endfunction

  // speed code limited to the three legal encodings
  function [1:0] spd_code;
    input [1:0] s;
    begin
      spd_code = (s == `SPD_S100 || s == `SPD_S200) ? s : `SPD_S400;
    end
  endfunction

  // fragment size in quadlets for classes 0 to 3
  wire [15:0] frag_q = `FRAG_QUADS << cls;
  wire [7:0]  n_sp   = sp_fit(count_ff, cls, tsi);
  wire        frag_ok = {{(15-AW){1'b0}}, count_ff} >= frag_q;

  // bus decode
  wire        wr_go   = aw_held_ff && w_held_ff && !s_axi_bvalid;
  wire        is_push = aw_addr_ff == `A_ACCESS || aw_addr_ff == `A_LAST_ACCESS;
  wire        in_push = in_valid && in_ready_ff;
  wire        bus_push = wr_go && is_push && !in_push && count_ff < DEPTH;
  wire        wr_done = wr_go && (!is_push || bus_push);
  reg         pop;
  reg         push;
  reg  [32:0] push_word;
  reg  [AW:0] nxt_count;
  reg  [AW:0] nxt_last_cnt;
  always @* begin
    pop = slot && (state_ff == S_RAW || (state_ff == S_DATA && !(header_insert_mode && stamp)));
    push = in_push || bus_push;
    push_word = in_push ? {in_last, in_data} : {aw_addr_ff == `A_LAST_ACCESS, w_data_ff};
    nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    nxt_last_cnt = last_cnt_ff + {{AW{1'b0}}, push && push_word[32]}
                   - {{AW{1'b0}}, pop && head[32]};
  end
  reg [31:0] rd_word;
  reg        rd_ok;
  always @* begin
    rd_ok = 1'b1;
    rd_word = `RST_ZERO;
    case (s_axi_araddr)
      `A_PORT_CFG:    rd_word = port_cfg_ff;
      `A_BUF_CFG0:    rd_word = buf_cfg_ff;
      `A_ISO_HDR:     rd_word = iso_hdr_ff;
      `A_CIP_FIRST:   rd_word = {cip_first_ff[31:8], dbc_ff};
      `A_CIP_SECOND:  rd_word = cip_second_ff;
      `A_EXTRA_HDR:   rd_word = extra_hdr_ff;
      `A_STATUS:      rd_word = {{(15-AW){1'b0}}, count_ff, 7'h00, state_ff != S_IDLE, dbc_ff};
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= `RST_ZERO;
      aw_addr_ff    <= 8'h00;
      aw_held_ff    <= 1'b0;
      w_data_ff     <= `RST_ZERO;
      w_strb_ff     <= 4'h0;
      w_held_ff     <= 1'b0;
      port_cfg_ff   <= `RST_ZERO;
      buf_cfg_ff    <= `RST_ZERO;
      iso_hdr_ff    <= `RST_ISO_HDR;
      cip_first_ff  <= `RST_CIP_FIRST;
      cip_second_ff <= `RST_CIP_SECOND;
      extra_hdr_ff  <= `RST_ZERO;
    end else if (ce) begin
      // ready is raised only while the holding slot is empty
      s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_ff && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
        aw_held_ff <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        w_held_ff <= 1'b1;
      end
      s_axi_bvalid <= s_axi_bvalid && !s_axi_bready;
      if (wr_done) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (aw_addr_ff)
          `A_PORT_CFG:    port_cfg_ff   <= merge(port_cfg_ff, w_data_ff, w_strb_ff);
          `A_BUF_CFG0:    buf_cfg_ff    <= merge(buf_cfg_ff, w_data_ff, w_strb_ff);
          `A_ISO_HDR:     iso_hdr_ff    <= merge(iso_hdr_ff, w_data_ff, w_strb_ff);
          `A_CIP_FIRST:   cip_first_ff  <= merge(cip_first_ff, w_data_ff, w_strb_ff);
          `A_CIP_SECOND:  cip_second_ff <= merge(cip_second_ff, w_data_ff, w_strb_ff);
          `A_EXTRA_HDR:   extra_hdr_ff  <= merge(extra_hdr_ff, w_data_ff, w_strb_ff);
          `A_ACCESS, `A_LAST_ACCESS: s_axi_bresp <= `RESP_OKAY;
          default:        s_axi_bresp   <= `RESP_SLVERR;
        endcase
      end
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // buffer pointers; writes are quadlets stored as given, never padded
  always @(posedge aclk) begin
    if (!aresetn) begin
      wptr_ff     <= {AW{1'b0}};
      rptr_ff     <= {AW{1'b0}};
      count_ff    <= {(AW+1){1'b0}};
      last_cnt_ff <= {(AW+1){1'b0}};
      in_ready_ff <= 1'b0;
    end else if (ce) begin
      if (push) begin
        mem[wptr_ff] <= push_word;
        wptr_ff <= wptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      rptr_ff <= rptr_ff + {{(AW-1){1'b0}}, pop};
      count_ff    <= nxt_count;
      last_cnt_ff <= nxt_last_cnt;
      // registered ready leaves one spare slot for the push in flight
      in_ready_ff <= nxt_count < DEPTH - 1;
    end
  end
  // packet sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff     <= S_IDLE;
      left_ff      <= 16'd0;
      len_ff       <= 16'd0;
      blocks_ff    <= 8'd0;
      sp_q_ff      <= 6'd0;
      dbc_ff       <= `RST_DBC;
      out_valid_ff <= 1'b0;
      out_data_ff  <= `RST_ZERO;
      out_first_ff <= 1'b0;
      out_last_ff  <= 1'b0;
      out_tcode_ff <= `TCODE_ISO;
    end else if (ce) begin
      out_tcode_ff <= `TCODE_ISO;
      if (wr_done && aw_addr_ff == `A_CIP_FIRST && w_strb_ff[0]) begin
        dbc_ff <= w_data_ff[7:0];
      end
      out_valid_ff <= out_valid_ff && !out_ready;
      case (state_ff)
        S_IDLE: begin
          if (cycle_start && header_insert_mode && mpeg) begin
            state_ff <= S_ISO;
            if (frac && frag_ok) begin
              left_ff   <= frag_q;
              len_ff    <= `CIP_BYTES + {frag_q[13:0], 2'b00};
              blocks_ff <= 8'd1;
            end else if (!frac && n_sp != 8'd0) begin
              left_ff   <= {8'd0, n_sp} * {10'd0, `SP_QUADS};
              len_ff    <= `CIP_BYTES + {1'b0, n_sp, 7'd0} + {2'b00, n_sp, 6'd0};
              blocks_ff <= n_sp;
            end else begin
              left_ff   <= 16'd0;
              len_ff    <= `CIP_BYTES;
              blocks_ff <= 8'd0;
            end
          end else if (cycle_start && !header_insert_mode && last_cnt_ff != {(AW+1){1'b0}}) begin
            state_ff <= S_RAW;
          end
        end
        S_ISO: begin
          if (slot) begin
            out_valid_ff <= 1'b1;
            out_first_ff <= 1'b1;
            out_last_ff  <= 1'b0;
            out_data_ff  <= {len_ff, `TAG_CIP, iso_hdr_ff[`CHAN_HI:`CHAN_LO],
                             spd_code(iso_hdr_ff[`SPD_HI:`SPD_LO]), 2'b00,
                             iso_hdr_ff[`SY_HI:0]};
            state_ff <= S_CIP0;
          end
        end
        S_CIP0: begin
          if (slot) begin
            out_valid_ff <= 1'b1;
            out_first_ff <= 1'b0;
            // hardware owns DBS, FN and DBC unless the debug override is set
            if (ovr) begin
              out_data_ff <= cip_first_ff;
            end else begin
              out_data_ff <= {cip_first_ff[31:24],
                              frac ? frag_q[7:0] : {2'b00, `SP_QUADS},
                              frac ? 2'd3 - cls[1:0] : `FN_WHOLE,
                              cip_first_ff[13:8], dbc_ff};
            end
            state_ff <= S_CIP1;
          end
        end
        S_CIP1: begin
          if (slot) begin
            out_valid_ff <= 1'b1;
            out_data_ff  <= cip_second_ff;
            out_last_ff  <= left_ff == 16'd0;
            dbc_ff       <= ovr ? dbc_ff : dbc_ff + blocks_ff;
            state_ff     <= left_ff == 16'd0 ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (slot) begin
            out_valid_ff <= 1'b1;
            out_data_ff  <= stamp ? ts_value : head[31:0];
            out_last_ff  <= left_ff == 16'd1;
            left_ff      <= left_ff - 16'd1;
            sp_q_ff      <= sp_q_ff == `SP_QUADS - 6'd1 ? 6'd0 : sp_q_ff + 6'd1;
            state_ff     <= left_ff == 16'd1 ? S_IDLE : S_DATA;
          end
        end
        S_RAW: begin
          if (slot) begin
            out_valid_ff <= 1'b1;
            out_first_ff <= !out_valid_ff || out_last_ff;
            out_data_ff  <= head[31:0];
            out_last_ff  <= head[32];
            state_ff     <= head[32] ? S_IDLE : S_RAW;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule

//--- verif/iso_tx_hdr_sva.sv
`timescale 1ns/1ns
module iso_tx_hdr_sva (
  input logic        aclk,
  input logic        aresetn,
  input logic        ce,
  input logic        out_valid_ff,
  input logic [31:0] out_data_ff,
  input logic        out_first_ff,
  input logic        out_last_ff,
  input logic [3:0]  out_tcode_ff,
  input logic        out_ready
);
  logic [15:0] cnt_ff;
  logic [15:0] len_ff;
  logic [7:0]  dbc_ff;
  logic        have_ff;
  logic        beat;
  logic [15:0] quads;
  assign beat = ce && out_valid_ff && out_ready;
  assign quads = (len_ff - 16'h0008) >> 2;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // beats per packet and the data block counter the next packet must carry
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff  <= 16'h0000;
      len_ff  <= 16'h0000;
      dbc_ff  <= 8'h00;
      have_ff <= 1'b0;
    end else if (beat) begin
      cnt_ff <= out_first_ff ? 16'h0001 : cnt_ff + 16'h0001;
      if (out_first_ff)
        len_ff <= out_data_ff[31:16];
      if (!out_first_ff && cnt_ff == 16'h0001) begin
        have_ff <= 1'b1;
        dbc_ff  <= out_data_ff[7:0] + ((quads == 16'h0000) ? 8'h00 :
                   (quads < 16'h0030) ? 8'h01 : 8'(quads / 16'h0030));
      end
    end
  end
  tcode_fixed_a: assert property (out_valid_ff |-> out_tcode_ff == 4'hA)
    else $error("transaction code wrong");
  header_tag_a: assert property (out_valid_ff && out_first_ff |-> out_data_ff[15:14] == 2'h1)
    else $error("tag field wrong");
  speed_code_a: assert property (out_valid_ff && out_first_ff |-> out_data_ff[7:6] != 2'h3)
    else $error("speed code undefined");
  pkt_length_a: assert property (beat && out_last_ff |-> {cnt_ff[13:0], 2'h0} == len_ff)
    else $error("length field disagrees with beats");
  pkt_size_a: assert property (out_valid_ff && out_first_ff |-> (out_data_ff[31:16] + 16'h000C) inside
    {16'h0014, 16'h002C, 16'h0044, 16'h0074, 16'h00D4, 16'h0194, 16'h0254, 16'h0314, 16'h03D4})
    else $error("packet size not allowed");
  hold_beat_a: assert property (out_valid_ff && !out_ready |=>
    out_valid_ff && $stable(out_data_ff) && $stable(out_last_ff))
    else $error("beat changed while stalled");
  first_once_a: assert property (beat && !out_last_ff |=> !(out_valid_ff && out_first_ff))
    else $error("first mark inside packet");
  dbc_step_a: assert property (beat && !out_first_ff && cnt_ff == 16'h0001 && have_ff |->
    out_data_ff[7:0] == dbc_ff)
    else $error("block counter step wrong");
  cover property (out_valid_ff && out_first_ff && out_data_ff[31:16] == 16'h0008);
  cover property (out_valid_ff && !out_ready);
  cover property (beat && out_last_ff && len_ff >= 16'h0188);
endmodule

//--- verif/stream_source.sv
`timescale 1ns/1ns
module stream_source (
  input  logic        aclk,
  input  logic        in_ready_ff,
  output logic        in_valid,
  output logic [31:0] in_data,
  output logic        in_last
);
  initial begin
    in_valid = 1'b0;
    in_data  = 32'h00000000;
    in_last  = 1'b0;
  end
  // raw payload only, one whole quadlet per beat; released data is inverted so it never looks held
  task send(input logic [31:0] base, input int n, input int gap);
    int i;
    i = 0;
    repeat (gap) @(posedge aclk);
    in_valid <= 1'b1;
    in_data  <= base;
    while (i < n) begin
      @(posedge aclk);
      if (in_ready_ff) begin
        i++;
        in_data <= (i < n) ? base + 32'(i) : ~(base + 32'(i - 1));
      end
    end
    in_valid <= 1'b0;
  endtask
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ns
`include "iso_tx_hdr_defs.vh"
module tb_top;
  logic        aclk, aresetn, ce, cycle_start, out_ready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, ts_value, in_data, out_data_ff, rd, base;
  logic [3:0]  s_axi_wstrb, out_tcode_ff;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        in_valid, in_last, in_ready_ff, out_valid_ff, out_first_ff, out_last_ff;
  logic [7:0]  dbc;
  logic [31:0] q[$], exp_q[$];
  int          failures, comparisons, nlast;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
  row_t rows [7] = '{
    '{1'b0, `A_ISO_HDR, 32'h0, `RST_ISO_HDR, `RESP_OKAY},
    '{1'b0, `A_CIP_FIRST, 32'h0, `RST_CIP_FIRST, `RESP_OKAY},
    '{1'b0, `A_CIP_SECOND, 32'h0, `RST_CIP_SECOND, `RESP_OKAY},
    '{1'b0, `A_PORT_CFG, 32'h0, `RST_ZERO, `RESP_OKAY},
    '{1'b0, `A_BUF_CFG0, 32'h0, `RST_ZERO, `RESP_OKAY},
    '{1'b1, `A_EXTRA_HDR, 32'h5A5AC3C3, 32'h5A5AC3C3, `RESP_OKAY},
    '{1'b0, 8'h28, 32'h0, `RST_ZERO, `RESP_SLVERR}};
  iso_mpeg2_tx_header_inserter i_iso_mpeg2_tx_header_inserter (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_ready_ff(in_ready_ff),
    .cycle_start(cycle_start), .ts_value(ts_value), .out_valid_ff(out_valid_ff), .out_data_ff(out_data_ff),
    .out_first_ff(out_first_ff), .out_last_ff(out_last_ff), .out_tcode_ff(out_tcode_ff), .out_ready(out_ready));
  stream_source i_stream_source (.aclk(aclk), .in_ready_ff(in_ready_ff), .in_valid(in_valid),
    .in_data(in_data), .in_last(in_last));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // sink stalls every other cycle
  always @(posedge aclk) out_ready <= !out_ready;
  always @(posedge aclk) begin
    if (out_valid_ff === 1'b1 && out_ready === 1'b1) begin
      q.push_back(out_data_ff);
      if (out_last_ff) nlast++;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end while (aw || w);
    while (!s_axi_bvalid) @(posedge aclk);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task feed(input int n, input int gap);
    for (int i = 0; i < n; i++) exp_q.push_back(base + 32'(i));
    i_stream_source.send(base, n, gap);
    base = base + 32'(n);
  endtask
  task pkt(input int n, input logic [15:0] lo, input int cls, input logic ts);
    int t, k;
    t = nlast;
    k = 0;
    @(posedge aclk);
    cycle_start <= 1'b1;
    @(posedge aclk);
    cycle_start <= 1'b0;
    while (nlast == t && k < 4000) begin
      @(posedge aclk);
      #1;
      k++;
    end
    if (k >= 4000) failures++;
    chk(32'(q.size()), 32'(3 + n));
    chk(q[0], {16'(8 + 4 * n), lo});
    if (n == 0) chk(q[1] & 32'h000000FF, 32'(dbc));
    else chk(q[1], {8'h00, cls < 4 ? 8'(6 << cls) : 8'h30, 2'(cls < 4 ? 3 - cls : 0), 6'h04, dbc});
    chk(q[2], `RST_CIP_SECOND);
    for (int i = 0; i < n; i++) chk(q[3 + i], (ts && i == 0) ? ts_value : exp_q.pop_front());
    dbc = dbc + 8'(n == 0 ? 0 : (cls < 4 ? 1 : n / 48));
    q.delete();
  endtask
  task complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    ce = 1'b1;
    cycle_start = 1'b0;
    out_ready = 1'b0;
    ts_value = 32'h7E57C0DE;
    base = 32'hD0000000;
    dbc = 8'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
        chk(32'(rr), 32'(`RESP_OKAY));
      end
      rd_reg(rows[i].a);
      chk(rd, rows[i].e);
      chk(32'(rr), 32'(rows[i].r));
    end
    wr(`A_PORT_CFG, 32'h00000001);
    for (int s = 0; s < 4; s++) begin
      wr(`A_ISO_HDR, {16'h0000, 2'h1, 6'h05, 2'(s), 6'h00});
      pkt(0, {2'h1, 6'h05, s == 3 ? 2'h2 : 2'(s), 6'h00}, 0, 1'b0);
    end
    wr(`A_PORT_CFG, 32'h00000041);
    wr(`A_BUF_CFG0, 32'h00000001);
    feed(47, 0);
    pkt(48, 16'h4580, 4, 1'b1);
    wr(`A_BUF_CFG0, 32'h00000000);
    for (int c = 0; c < 4; c++) begin
      wr(`A_PORT_CFG, 32'(c << 4) | 32'h00000001);
      if (c == 0) begin
        for (int i = 0; i < 6; i++) begin
          wr(i == 5 ? `A_LAST_ACCESS : `A_ACCESS, base);
          exp_q.push_back(base);
          base = base + 32'h00000001;
        end
      end else feed(6 << c, c);
      pkt(6 << c, 16'h4580, c, 1'b0);
    end
    wr(`A_PORT_CFG, 32'h00000071);
    feed(96, 0);
    pkt(96, 16'h4580, 7, 1'b0);
    rd_reg(`A_STATUS);
    chk(rd, 32'(dbc));
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(`A_ISO_HDR);
    chk(rd, `RST_ISO_HDR);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    complete_run();
  end
endmodule
bind iso_mpeg2_tx_header_inserter iso_tx_hdr_sva i_iso_tx_hdr_sva (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .out_valid_ff(out_valid_ff), .out_data_ff(out_data_ff), .out_first_ff(out_first_ff),
  .out_last_ff(out_last_ff), .out_tcode_ff(out_tcode_ff), .out_ready(out_ready));
